// >>> itfm_cfg.svh
// Purpose: constants of the input terminal function map
// Assumes: 100 MHz mclk
// Notes:   function codes, vector bit positions, offsets, reset values
`ifndef ITFM_CFG_SVH
`define ITFM_CFG_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_KHZ        100000
`define RESP_FAST_MS   2
`define RESP_SLOW_MS   20
`define SLOW_TICK_MS   10

// ----------------------------------------------------------------
// function codes
// ----------------------------------------------------------------
`define FC_LOW      14'h0000
`define FC_MID      14'h0001
`define FC_HIGH     14'h0002
`define FC_SECOND   14'h0003
`define FC_CUR_IN   14'h0004
`define FC_JOG      14'h0005
`define FC_THERM    14'h0007
`define FC_FIFTEEN  14'h0008
`define FC_RUN_EN   14'h000A
`define FC_ILOCK    14'h000C
`define FC_CLOOP    14'h000E
`define FC_PEXT     14'h0010
`define FC_PREEXC   14'h0017
`define FC_OUTSTOP  14'h0018
`define FC_SHOLD    14'h0019
`define FC_STOPPER  14'h001D
`define FC_JOG_SELECT_TWO     14'h001E
`define FC_PPI      14'h002C
`define FC_FWD      14'h003C
`define FC_REV      14'h003D
`define FC_RESET    14'h003E
`define FC_PNET     14'h0041
`define FC_ENET     14'h0042
`define FC_CSRC     14'h0043
`define FC_PROX     14'h004C
`define FC_SERVO    14'h0056
`define FC_SUDDEN   14'h0057
`define FC_FSTROKE  14'h0058
`define FC_RSTROKE  14'h0059
`define FC_NONE     14'h270F

// ----------------------------------------------------------------
// function vector bit positions
// ----------------------------------------------------------------
`define FB_LOW      0
`define FB_MID      1
`define FB_HIGH     2
`define FB_SECOND   3
`define FB_CUR_IN   4
`define FB_JOG      5
`define FB_THERM    6
`define FB_FIFTEEN  7
`define FB_RUN_EN   8
`define FB_ILOCK    9
`define FB_CLOOP    10
`define FB_PEXT     11
`define FB_PREEXC   12
`define FB_OUTSTOP  13
`define FB_SHOLD    14
`define FB_STOPPER  15
`define FB_JOG_SELECT_TWO     16
`define FB_PPI      17
`define FB_FWD      18
`define FB_REV      19
`define FB_RESET    20
`define FB_PNET     21
`define FB_ENET     22
`define FB_CSRC     23
`define FB_PROX     24
`define FB_SERVO    25
`define FB_SUDDEN   26
`define FB_FSTROKE  27
`define FB_RSTROKE  28
`define FB_RCLR     29
`define FB_RDEC     30
`define FB_RACC     31
`define FAST_MASK   32'h00002300

// ----------------------------------------------------------------
// terminals, offsets, reset values
// ----------------------------------------------------------------
`define TERM_FWD      3'h0
`define TERM_REV      3'h1
`define OPMODE_ILOCK  4'h7
`define OFS_SEL_LAST  8'h18
`define OFS_REMOTE    8'h1C
`define OFS_OPMODE    8'h20
`define OFS_CTRL      8'h24
`define OFS_FNSTAT    8'h28
`define OFS_PINSTAT   8'h2C
`define RST_SEL0      14'h003C
`define RST_SEL1      14'h003D
`define RST_SEL2      14'h0000
`define RST_SEL3      14'h0001
`define RST_SEL4      14'h0002
`define RST_SEL5      14'h0018
`define RST_SEL6      14'h003E
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// >>> itfm_contacts.sv
// Purpose: contacts and relays wired to the seven input terminals
// Assumes: bench sets the wanted pattern at mclk rising edges
// Notes:   changed contacts chatter three cycles before settling
`default_nettype none

module itfm_contacts (
  input  wire logic       mclk,
  input  wire logic [6:0] want,
  output var  logic [6:0] term_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] last   = 7'h00;
  logic [6:0] chg    = 7'h00;
  int         bounce = 0;
  always @(posedge mclk) begin
    if (want != last) begin
      chg <= want ^ last;
      last <= want;
      bounce <= 3;
    end else if (bounce > 0) begin
      bounce <= bounce - 1;
    end
    term_in <= (bounce % 2 == 1) ? (last ^ chg) : last;
  end
endmodule

`default_nettype wire

// >>> itfm_pkg.sv
// Purpose: types of the input terminal function map
// Assumes: itfm_cfg.svh constants
// Notes:   whole module state is one packed struct
`include "itfm_cfg.svh"
`default_nettype none

package itfm_pkg;

  typedef struct packed {
    logic [6:0][13:0] sel;
    logic [15:0]      remote;
    logic [3:0]       opmode;
    logic             posmode;
    logic [6:0]       s1;
    logic [6:0]       s2;
    logic [6:0]       s3;
    logic [6:0]       stable;
    logic [23:0]      div;
    logic [31:0]      fn;
    logic [2:0]       spd_src;
    logic             volt_valid;
    logic             aw_hold;
    logic [7:0]       awaddr;
    logic             w_hold;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } itfm_state_t;

endpackage

`default_nettype wire

// >>> itfm_top.sv
// Purpose: maps seven contact inputs onto internal control functions
// Assumes: contacts are asynchronous; high level means contact closed
// Notes:   selectors and settings over AXI4-Lite; function vector registered
//
// Summary of operation
// - seven selectors, reset terminal defaults reset
// - shared function code ORs its terminals
// - jog beats multi-speed beats closed-loop
// - output stop doubles as missing run enable, and as missing interlock in opmode 7
// - nonzero remote setting remaps speed inputs outside position mode
// - current select invalidates voltage input
// - run enable, output stop within 2ms
// - other functions act within 20ms
// - thermal relay asserted on open contact
// - run codes only on own terminals
// - code 65 selects panel else network
// - code 66 selects network else external
// - code 67 validates alternate command sources
`include "itfm_cfg.svh"
`default_nettype none

module itfm_top
  import itfm_pkg::*;
#(
  parameter int unsigned SLOW_TICK_CYCLES = `SLOW_TICK_MS * `CLK_KHZ
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic [6:0]  term_in,
  output var  logic [31:0] fn_active,
  output var  logic [2:0]  speed_src,
  output var  logic        volt_in_valid,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  localparam logic [23:0] TICK_LAST = 24'(SLOW_TICK_CYCLES - 1);

  localparam itfm_state_t ST_RST = '{
    sel:     {`RST_SEL6, `RST_SEL5, `RST_SEL4, `RST_SEL3,
              `RST_SEL2, `RST_SEL1, `RST_SEL0},
    default: '0
  };

  itfm_state_t q;
  itfm_state_t d;
  logic [31:0] hit [7];
  logic [6:0]  is_run_en;
  logic [6:0]  is_ilock;
  logic [31:0] raw;
  logic [31:0] fn_new;
  logic [32:0] rd_mux;
  logic [32:0] wr_mux;
  logic [31:0] wr_val;
  logic        tick;

  // ----------------------------------------------------------------
  // per terminal decode
  // ----------------------------------------------------------------
  generate
    for (genvar t = 0; t < 7; t++) begin : g_term
      logic       act;
      logic [2:0] tid;
      assign act          = q.stable[t];
      assign tid          = 3'(t);
      assign is_run_en[t] = (q.sel[t] == `FC_RUN_EN);
      assign is_ilock[t]  = (q.sel[t] == `FC_ILOCK);
      always_comb begin
        hit[t] = '0;
        case (q.sel[t])
          `FC_LOW:     hit[t][`FB_LOW]     = act;
          `FC_MID:     hit[t][`FB_MID]     = act;
          `FC_HIGH:    hit[t][`FB_HIGH]    = act;
          `FC_SECOND:  hit[t][`FB_SECOND]  = act;
          `FC_CUR_IN:  hit[t][`FB_CUR_IN]  = act;
          `FC_JOG:     hit[t][`FB_JOG]     = act;
          `FC_THERM:   hit[t][`FB_THERM]   = !act;
          `FC_FIFTEEN: hit[t][`FB_FIFTEEN] = act;
          `FC_RUN_EN:  hit[t][`FB_RUN_EN]  = act;
          `FC_ILOCK:   hit[t][`FB_ILOCK]   = act;
          `FC_CLOOP:   hit[t][`FB_CLOOP]   = act;
          `FC_PEXT:    hit[t][`FB_PEXT]    = act;
          `FC_PREEXC:  hit[t][`FB_PREEXC]  = act;
          `FC_OUTSTOP: hit[t][`FB_OUTSTOP] = act;
          `FC_SHOLD:   hit[t][`FB_SHOLD]   = act;
          `FC_STOPPER: hit[t][`FB_STOPPER] = act;
          `FC_JOG_SELECT_TWO:    hit[t][`FB_JOG_SELECT_TWO]    = act;
          `FC_PPI:     hit[t][`FB_PPI]     = act;
          `FC_FWD:     hit[t][`FB_FWD]     = act && (tid == `TERM_FWD);
          `FC_REV:     hit[t][`FB_REV]     = act && (tid == `TERM_REV);
          `FC_RESET:   hit[t][`FB_RESET]   = act;
          `FC_PNET:    hit[t][`FB_PNET]    = act;
          `FC_ENET:    hit[t][`FB_ENET]    = act;
          `FC_CSRC:    hit[t][`FB_CSRC]    = act;
          `FC_PROX:    hit[t][`FB_PROX]    = act;
          `FC_SERVO:   hit[t][`FB_SERVO]   = act;
          `FC_SUDDEN:  hit[t][`FB_SUDDEN]  = act;
          `FC_FSTROKE: hit[t][`FB_FSTROKE] = act;
          `FC_RSTROKE: hit[t][`FB_RSTROKE] = act;
          default:     hit[t]              = '0;
        endcase
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // function combination
  // ----------------------------------------------------------------
  always_comb begin
    raw = '0;
    for (int i = 0; i < 7; i++) begin
      raw = raw | hit[i];
    end
    fn_new = raw;
    fn_new[`FB_RUN_EN] = raw[`FB_RUN_EN] | (~|is_run_en & raw[`FB_OUTSTOP]);
    fn_new[`FB_ILOCK]  = raw[`FB_ILOCK] |
                         (~|is_ilock & (q.opmode == `OPMODE_ILOCK) & raw[`FB_OUTSTOP]);
    if ((q.remote != 16'h0000) && !q.posmode) begin
      fn_new[`FB_RCLR] = raw[`FB_LOW];
      fn_new[`FB_RDEC] = raw[`FB_MID];
      fn_new[`FB_RACC] = raw[`FB_HIGH];
      fn_new[`FB_LOW]  = 1'h0;
      fn_new[`FB_MID]  = 1'h0;
      fn_new[`FB_HIGH] = 1'h0;
    end
    if (q.posmode) begin
      fn_new[`FB_CLOOP]   = 1'h0;
      fn_new[`FB_PPI]     = 1'h0;
      fn_new[`FB_SHOLD]   = 1'h0;
      fn_new[`FB_SECOND]  = 1'h0;
      fn_new[`FB_CUR_IN]  = 1'h0;
      fn_new[`FB_FIFTEEN] = 1'h0;
    end else begin
      fn_new[`FB_PROX]    = 1'h0;
      fn_new[`FB_SUDDEN]  = 1'h0;
      fn_new[`FB_FSTROKE] = 1'h0;
      fn_new[`FB_RSTROKE] = 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  function automatic logic [32:0] reg_mux(input logic [7:0] a, input itfm_state_t s);
    logic [32:0] r;
    r = {1'h1, 32'h00000000};
    if (a[1:0] != 2'h0) begin
      r = {1'h1, 32'h00000000};
    end else if (a <= `OFS_SEL_LAST) begin
      r = {1'h0, 18'h00000, s.sel[a[4:2]]};
    end else begin
      case (a)
        `OFS_REMOTE:  r = {1'h0, 16'h0000, s.remote};
        `OFS_OPMODE:  r = {1'h0, 28'h0000000, s.opmode};
        `OFS_CTRL:    r = {1'h0, 31'h00000000, s.posmode};
        `OFS_FNSTAT:  r = {1'h0, s.fn};
        `OFS_PINSTAT: r = {1'h0, 21'h000000, s.spd_src, s.volt_valid, s.stable};
        default:      r = {1'h1, 32'h00000000};
      endcase
    end
    return r;
  endfunction

  always_comb begin
    rd_mux = reg_mux(s_axi_araddr, q);
    wr_mux = reg_mux(q.awaddr, q);
    for (int b = 0; b < 4; b++) begin
      wr_val[b*8 +: 8] = q.wstrb[b] ? q.wdata[b*8 +: 8] : wr_mux[b*8 +: 8];
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    // pin synchroniser, change taken when stages two and three agree
    d.s1 = term_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < 7; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.stable[i] = q.s3[i];
      end
    end
    tick  = (q.div >= TICK_LAST);
    d.div = tick ? 24'h000000 : q.div + 24'h000001;
    d.fn = (fn_new & `FAST_MASK) | (q.fn & ~`FAST_MASK);
    if (tick) begin
      d.fn         = fn_new;
      d.volt_valid = !fn_new[`FB_CUR_IN];
      if (fn_new[`FB_JOG] | fn_new[`FB_JOG_SELECT_TWO]) begin
        d.spd_src = 3'h4;
      end else if (fn_new[`FB_LOW] | fn_new[`FB_MID] | fn_new[`FB_HIGH] |
                   fn_new[`FB_FIFTEEN]) begin
        d.spd_src = 3'h2;
      end else if (fn_new[`FB_CLOOP]) begin
        d.spd_src = 3'h1;
      end else begin
        d.spd_src = 3'h0;
      end
    end
    if (fn_new[`FB_CUR_IN] && tick) begin
      d.volt_valid = 1'h0;
    end

    // write channel
    if (s_axi_awvalid && q.awready) begin
      d.aw_hold = 1'h1;
      d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_hold = 1'h1;
      d.wdata  = s_axi_wdata;
      d.wstrb  = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'h0;
    end
    if (q.aw_hold && q.w_hold && !q.bvalid) begin
      d.aw_hold = 1'h0;
      d.w_hold  = 1'h0;
      d.bvalid  = 1'h1;
      d.bresp   = `RESP_OKAY;
      if (wr_mux[32]) begin
        d.bresp = `RESP_SLVERR;
      end else if (q.awaddr <= `OFS_SEL_LAST) begin
        d.sel[q.awaddr[4:2]] = wr_val[13:0];
      end else begin
        case (q.awaddr)
          `OFS_REMOTE: d.remote  = wr_val[15:0];
          `OFS_OPMODE: d.opmode  = wr_val[3:0];
          `OFS_CTRL:   d.posmode = wr_val[0];
          default:     d.bresp   = `RESP_SLVERR;
        endcase
      end
    end
    d.awready = !d.aw_hold;
    d.wready  = !d.w_hold;

    // read channel
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'h0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'h1;
      d.rdata  = rd_mux[31:0];
      d.rresp  = rd_mux[32] ? `RESP_SLVERR : `RESP_OKAY;
    end
    d.arready = !d.rvalid;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign fn_active     = q.fn;
  assign speed_src     = q.spd_src;
  assign volt_in_valid = q.volt_valid;
  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign s_axi_rvalid  = q.rvalid;

endmodule

`default_nettype wire

// >>> itfm_top_properties.sv
// Purpose: concurrent checks on the terminal function map ports
// Assumes: one mclk domain, rstn active low
// Notes:   bound into itfm_top below
`include "itfm_cfg.svh"
`default_nettype none

module itfm_chk
  import itfm_pkg::*;
#(
  parameter int unsigned SLOW_TICK_CYCLES = 16
) (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic [31:0] fn_active,
  input wire logic [2:0]  speed_src,
  input wire logic        volt_in_valid,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_aw_closed: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("awready stayed high after address taken");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_speed_onehot: assert property ($onehot0(speed_src))
    else $error("several speed sources at once");
  a_jog_first: assert property (fn_active[`FB_JOG] || fn_active[`FB_JOG_SELECT_TWO] |-> speed_src == 3'h4)
    else $error("jog lost priority");
  a_volt_invalid: assert property (fn_active[`FB_CUR_IN] |-> !volt_in_valid)
    else $error("voltage input valid under current select");
  a_remote_excl: assert property (|fn_active[31:29] |-> fn_active[2:0] == 3'h0)
    else $error("speed select and remote active together");
endmodule

bind itfm_top itfm_chk #(.SLOW_TICK_CYCLES(SLOW_TICK_CYCLES)) u_itfm_chk (
  .mclk, .rstn, .fn_active, .speed_src, .volt_in_valid, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);

`default_nettype wire

// >>> itfm_top_tb.sv
// Purpose: self-checking bench of the terminal function map
// Assumes: short slow tick, contacts modelled by itfm_contacts
// Notes:   registers reached over AXI4-Lite tasks
`include "itfm_cfg.svh"
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("Error at %0t got %0h expected %0h", $time, (g), (e)); end end

module itfm_top_tb
  import itfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 200;
  logic        mclk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rvalid, s_axi_rready, volt_in_valid;
  logic        s_axi_awready, s_axi_wready, s_axi_arready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, fn_active, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [2:0]  speed_src;
  logic [6:0]  want, term_in;
  int          errors, samples_checked;
  logic [13:0] rst_sel [7] = '{`RST_SEL0, `RST_SEL1, `RST_SEL2, `RST_SEL3, `RST_SEL4,
                              `RST_SEL5, `RST_SEL6};
  logic [13:0] codes [17] = '{`FC_CLOOP, `FC_PEXT, `FC_PREEXC, `FC_OUTSTOP, `FC_SHOLD,
    `FC_STOPPER, `FC_JOG_SELECT_TWO, `FC_PPI, `FC_RESET, `FC_PNET, `FC_ENET, `FC_CSRC, `FC_SERVO,
    `FC_PROX, `FC_SUDDEN, `FC_FSTROKE, `FC_RSTROKE};
  int          fbit [17] = '{10, 11, 12, 13, 14, 15, 16, 17, 20, 21, 22, 23, 25, 24, 26, 27, 28};

  itfm_top #(.SLOW_TICK_CYCLES(TICK)) u_itfm_top (.mclk, .rstn, .term_in, .fn_active,
    .speed_src, .volt_in_valid, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  itfm_contacts u_itfm_contacts (.mclk, .want, .term_in);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic close_out(input bit hung);
    if (hung) errors++;
    $display("Checks %0d, errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [13:0] v, output logic [1:0] rs);
    int   n;
    logic ah, wh, bh;
    n = 0;
    bh = 1'b0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {18'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!bh) begin
      @(negedge mclk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge mclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (bh) s_axi_bready <= 1'b0;
      n++;
      if (n > 200) close_out(1'b1);
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
    int   n;
    logic ah, rh;
    n = 0;
    rh = 1'b0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rh) begin
      @(negedge mclk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      dv = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge mclk);
      if (ah) s_axi_arvalid <= 1'b0;
      if (rh) s_axi_rready <= 1'b0;
      n++;
      if (n > 200) close_out(1'b1);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [13:0] v);
    logic [1:0] rs;
    axi_wr(a, v, rs);
  endtask

  // sets the contacts, then waits cyc cycles and samples at the falling edge
  task automatic pins(input logic [6:0] v, input int cyc);
    @(posedge mclk);
    want <= v;
    repeat (cyc) @(posedge mclk);
    @(negedge mclk);
  endtask

  initial begin
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, want, errors, samples_checked} = '0;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 7; i++) begin
      axi_rd(8'(i * 4), d, r);
      `CHK(d[13:0], rst_sel[i])
    end
    axi_rd(8'h30, d, r);
    `CHK(r, `RESP_SLVERR)
    axi_wr(`OFS_FNSTAT, 14'h0001, r);
    `CHK(r, `RESP_SLVERR)
    pins(7'h20, 12);
    `CHK(fn_active[`FB_OUTSTOP], 1'b1)
    `CHK(fn_active[`FB_RUN_EN], 1'b1)
    `CHK(fn_active[`FB_ILOCK], 1'b0)
    pins(7'h00, 12);
    `CHK(fn_active[`FB_RUN_EN], 1'b0)
    wr(`OFS_OPMODE, 14'h0007);
    axi_rd(`OFS_OPMODE, d, r);
    `CHK(d, 32'h00000007)
    pins(7'h20, 12);
    `CHK(fn_active[`FB_ILOCK], 1'b1)
    pins(7'h00, 12);
    `CHK(fn_active[`FB_ILOCK], 1'b0)
    wr(`OFS_OPMODE, 14'h0000);
    wr(8'h08, `FC_JOG);
    wr(8'h0C, `FC_JOG);
    pins(7'h18, 3 * TICK + 12);
    `CHK(fn_active[`FB_JOG], 1'b1)
    `CHK(speed_src, 3'h4)
    pins(7'h10, 3 * TICK + 12);
    `CHK(speed_src, 3'h2)
    pins(7'h04, 3 * TICK + 12);
    `CHK(fn_active[`FB_JOG], 1'b1)
    wr(8'h10, `FC_THERM);
    pins(7'h00, 3 * TICK + 12);
    `CHK(fn_active[`FB_THERM], 1'b1)
    pins(7'h10, 3 * TICK + 12);
    `CHK(fn_active[`FB_THERM], 1'b0)
    wr(8'h08, `FC_FWD);
    pins(7'h04, 3 * TICK + 12);
    `CHK(fn_active[`FB_FWD], 1'b0)
    pins(7'h05, 3 * TICK + 12);
    `CHK(fn_active[`FB_FWD], 1'b1)
    wr(8'h08, `FC_LOW);
    wr(`OFS_REMOTE, 14'h0001);
    pins(7'h04, 3 * TICK + 12);
    `CHK(fn_active[`FB_RCLR], 1'b1)
    `CHK(fn_active[`FB_LOW], 1'b0)
    wr(`OFS_REMOTE, 14'h0000);
    wr(8'h0C, `FC_CUR_IN);
    pins(7'h08, 3 * TICK + 12);
    `CHK(volt_in_valid, 1'b0)
    pins(7'h00, 3 * TICK + 12);
    `CHK(volt_in_valid, 1'b1)
    for (int k = 0; k < 17; k++) begin
      wr(`OFS_CTRL, {13'h0, k > 12});
      wr(8'h18, codes[k]);
      pins(7'h40, 3 * TICK + 12);
      `CHK(fn_active[fbit[k]], 1'b1)
      if (k == 0) `CHK(speed_src, 3'h1)
      pins(7'h00, 3 * TICK + 12);
      `CHK(fn_active[fbit[k]], 1'b0)
    end
    wr(8'h18, `FC_CLOOP);
    pins(7'h40, 3 * TICK + 12);
    `CHK(fn_active[`FB_CLOOP], 1'b0)
    wr(`OFS_CTRL, 14'h0000);
    wr(8'h18, `FC_PROX);
    pins(7'h40, 3 * TICK + 12);
    `CHK(fn_active[`FB_PROX], 1'b0)
    axi_rd(8'h18, d, r);
    `CHK(d[13:0], `FC_PROX)
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    @(negedge mclk);
    `CHK(fn_active, 32'h00000000)
    axi_rd(8'h18, d, r);
    `CHK(d[13:0], `RST_SEL6)
    close_out(1'b0);
  end
endmodule

`default_nettype wire
